// file: logic/rxap_regs.vh
// constants of the receiver auto-poll sequencer and serial config port
// assumes a 40 MHz mclk; included by rxap_top by bare name
`ifndef RXAP_REGS_VH
`define RXAP_REGS_VH

`define RXAP_CFG_W          20
`define RXAP_CFG_RESET      20'h42E78
`define RXAP_BIT_SQUELCH    17
`define RXAP_BIT_POLL_EN    15
`define RXAP_FLD_SLEEP_HI   14
`define RXAP_FLD_SLEEP_LO   12
`define RXAP_FLD_WIN_HI     11
`define RXAP_FLD_WIN_LO     9
`define RXAP_FLD_RUN_HI     8
`define RXAP_FLD_RUN_LO     7
`define RXAP_FLD_SLICE_HI   6
`define RXAP_FLD_SLICE_LO   5
`define RXAP_FLD_BW_HI      4
`define RXAP_FLD_BW_LO      3

`define RXAP_MCLK_HZ        40000000
`define RXAP_MCLK_NS        25
`define RXAP_SLEEP_BASE_MS  10
`define RXAP_SCLK_MIN_HZ    5000
`define RXAP_T1_MAX_NS      100
`define RXAP_BAD_LIMIT      4

`endif

// file: logic/rxap_sync.v
// two flip-flop synchroniser for asynchronous pin levels
// assumes inputs unrelated to clk
`timescale 1ns/1ps
`default_nettype none
module rxap_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         srst,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk) begin
        if (srst) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// file: logic/rxap_bitcheck.v
// pulse width checker: grades each mark or space against a window
// assumes a synchronised slicer level on the same clock
`timescale 1ns/1ps
`default_nettype none
module rxap_bitcheck #(
    parameter CW = 16
) (
    input  wire          clk,
    input  wire          srst,
    input  wire          enable,
    input  wire          level,
    input  wire [CW-1:0] window_cyc,
    output reg           valid_bit,
    output reg           bad_bit
);
    reg [CW-1:0] run_reg;
    reg          prev_reg;
    wire         edge_seen = level ^ prev_reg;

    always @(posedge clk) begin
        if (srst) begin
            run_reg   <= {CW{1'b0}};
            prev_reg  <= 1'b0;
            valid_bit <= 1'b0;
            bad_bit   <= 1'b0;
        end else begin
            prev_reg  <= level;
            valid_bit <= 1'b0;
            bad_bit   <= 1'b0;
            if (!enable) begin
                run_reg <= {CW{1'b0}};
            end else if (edge_seen) begin
                valid_bit <= (run_reg > window_cyc);
                bad_bit   <= (run_reg < window_cyc);
                run_reg   <= {{(CW-1){1'b0}}, 1'b1};
            end else if (run_reg != {CW{1'b1}}) begin
                run_reg <= run_reg + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/rxap_top.v
// auto-poll sequencer and serial configuration port of the receiver
// assumes mclk at 40 MHz; sclk, data pin and slicer level are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "rxap_regs.vh"
module rxap_top #(
    parameter SLEEP_BASE_CYC = `RXAP_SLEEP_BASE_MS * (`RXAP_MCLK_HZ / 1000),
    parameter SCLK_TIMEOUT_CYC = `RXAP_MCLK_HZ / `RXAP_SCLK_MIN_HZ
) (
    input  wire        mclk,
    input  wire        srst,
    input  wire        sclk_pin,
    input  wire        data_pin_in,
    output reg         data_pin_out,
    output wire        data_pin_oe,
    input  wire        slicer_raw,
    input  wire        squelch_pin,
    input  wire        band_select_pin_low,
    input  wire        band_select_pin_high,
    output reg  [19:0] cfg_word,
    output reg         squelch_disable,
    output reg  [1:0]  slice_level_sel,
    output reg  [1:0]  demod_bw_sel,
    output reg  [1:0]  band_select,
    output reg         sleep_active,
    output reg         poll_active,
    output reg         prog_active
);
    // longest allowed sclk-to-input time, in cycles (rounded down)
    localparam T1_MAX_CYC = `RXAP_T1_MAX_NS / `RXAP_MCLK_NS;

    localparam P_IDLE  = 3'h0;
    localparam P_ARM   = 3'h1;
    localparam P_LOW   = 3'h2;
    localparam P_HIGH  = 3'h3;
    localparam P_PULSE = 3'h4;
    localparam P_SHIFT = 3'h5;
    localparam P_STOP1 = 3'h6;
    localparam P_STOP2 = 3'h7;

    localparam A_AWAKE = 2'h0;
    localparam A_SLEEP = 2'h1;
    localparam A_POLL  = 2'h2;

    wire [4:0] pins_s;
    wire       sclk_s   = pins_s[0];
    wire       din_s    = pins_s[1];
    wire       slicer_s = pins_s[2];
    wire       sq_s     = pins_s[3];

    rxap_sync #(
        .W (5)
    ) u_sync (
        .clk      (mclk),
        .srst     (srst),
        .async_in ({band_select_pin_high, squelch_pin, slicer_raw, data_pin_in, sclk_pin}),
        .sync_out (pins_s)
    );

    reg         sclk_d_reg;
    reg         din_d_reg;
    reg  [2:0]  pstate_reg;
    reg  [2:0]  pstate_next;
    reg  [19:0] shift_reg;
    reg  [4:0]  nbits_reg;
    reg  [31:0] idle_cnt_reg;
    reg  [1:0]  astate_reg;
    reg  [31:0] sleep_cnt_reg;
    reg  [4:0]  valid_cnt_reg;
    reg  [2:0]  bad_cnt_reg;
    reg  [1:0]  band_low_reg;
    wire        sclk_rise = sclk_s & ~sclk_d_reg;
    wire        sclk_fall = ~sclk_s & sclk_d_reg;
    wire        din_rise  = din_s & ~din_d_reg;
    wire        din_fall  = ~din_s & din_d_reg;
    wire        apply     = (pstate_reg == P_STOP2) && sclk_fall;
    wire        timeout   = (pstate_reg != P_IDLE) && (idle_cnt_reg >= SCLK_TIMEOUT_CYC);

    // pin released as soon as synchronised sclk is high
    assign data_pin_oe = (pstate_reg == P_IDLE) && !sclk_s;

    // framing of start, data and stop sequences
    always @* begin
        pstate_next = pstate_reg;
        case (pstate_reg)
            P_IDLE:  if (sclk_s) pstate_next = P_ARM;
            P_ARM:   if (sclk_fall) pstate_next = din_s ? P_IDLE : P_LOW;
            P_LOW: begin
                if (din_rise) pstate_next = P_IDLE;
                else if (sclk_rise) pstate_next = P_HIGH;
            end
            P_HIGH: begin
                if (sclk_fall) pstate_next = P_IDLE;
                else if (din_rise) pstate_next = P_PULSE;
            end
            P_PULSE: begin
                if (sclk_fall) pstate_next = P_IDLE;
                else if (din_fall) pstate_next = P_SHIFT;
            end
            P_SHIFT: if (sclk_s && din_rise) pstate_next = P_STOP1;
            P_STOP1: begin
                if (sclk_fall) pstate_next = P_SHIFT;
                else if (din_fall) pstate_next = P_STOP2;
            end
            P_STOP2: if (sclk_fall) pstate_next = P_IDLE;
            default: pstate_next = P_IDLE;
        endcase
        if (timeout) pstate_next = P_IDLE;
    end

    // per-bit merge: only the low nbits positions take shifted data
    wire [19:0] cfg_merged;
    genvar gi;
    generate
        for (gi = 0; gi < 20; gi = gi + 1) begin : g_merge
            assign cfg_merged[gi] = (gi < nbits_reg) ? shift_reg[gi] : cfg_word[gi];
        end
    endgenerate

    always @(posedge mclk) begin
        if (srst) begin
            sclk_d_reg   <= 1'b0;
            din_d_reg    <= 1'b0;
            pstate_reg   <= P_IDLE;
            shift_reg    <= 20'h00000;
            nbits_reg    <= 5'h00;
            idle_cnt_reg <= 32'h00000000;
            cfg_word     <= `RXAP_CFG_RESET;
        end else begin
            sclk_d_reg <= sclk_s;
            din_d_reg  <= din_s;
            pstate_reg <= pstate_next;
            if (pstate_reg == P_IDLE || sclk_rise || sclk_fall)
                idle_cnt_reg <= 32'h00000000;
            else
                idle_cnt_reg <= idle_cnt_reg + 32'h00000001;
            if (pstate_reg == P_PULSE) begin
                shift_reg <= 20'h00000;
                nbits_reg <= 5'h00;
            end else if (pstate_reg == P_SHIFT && sclk_rise) begin
                shift_reg <= {shift_reg[18:0], din_s};
                if (nbits_reg != 5'h14) nbits_reg <= nbits_reg + 5'h01;
            end
            // a data bit whose rise was a stop pulse start is kept: shift_reg and nbits hold
            if (pstate_reg == P_STOP1 && sclk_fall) begin
                shift_reg <= shift_reg;
            end
            if (apply) cfg_word <= cfg_merged;
        end
    end

    // check window in microseconds at the upper band, by {code, bandwidth}
    function [9:0] win_us;
        input [4:0] sel;
        begin
            case (sel)
                5'h00: win_us = 10'h23A;
                5'h01: win_us = 10'h11D;
                5'h02: win_us = 10'h08F;
                5'h03: win_us = 10'h047;
                5'h04: win_us = 10'h214;
                5'h05: win_us = 10'h10A;
                5'h06: win_us = 10'h085;
                5'h07: win_us = 10'h043;
                5'h08: win_us = 10'h1EE;
                5'h09: win_us = 10'h0F7;
                5'h0A: win_us = 10'h07C;
                5'h0B: win_us = 10'h03E;
                5'h0C: win_us = 10'h1C9;
                5'h0D: win_us = 10'h0E4;
                5'h0E: win_us = 10'h072;
                5'h0F: win_us = 10'h039;
                5'h10: win_us = 10'h1A3;
                5'h11: win_us = 10'h0D1;
                5'h12: win_us = 10'h069;
                5'h13: win_us = 10'h034;
                5'h14: win_us = 10'h17D;
                5'h15: win_us = 10'h0BE;
                5'h16: win_us = 10'h05F;
                5'h17: win_us = 10'h030;
                5'h18: win_us = 10'h157;
                5'h19: win_us = 10'h0AC;
                5'h1A: win_us = 10'h056;
                5'h1B: win_us = 10'h02B;
                5'h1C: win_us = 10'h131;
                5'h1D: win_us = 10'h098;
                5'h1E: win_us = 10'h04C;
                5'h1F: win_us = 10'h026;
                default: win_us = 10'h131;
            endcase
        end
    endfunction

    wire [2:0]  win_code  = cfg_word[`RXAP_FLD_WIN_HI:`RXAP_FLD_WIN_LO];
    wire [1:0]  bw_code   = cfg_word[`RXAP_FLD_BW_HI:`RXAP_FLD_BW_LO];
    wire [2:0]  sleep_sel = cfg_word[`RXAP_FLD_SLEEP_HI:`RXAP_FLD_SLEEP_LO];
    wire [1:0]  run_sel   = cfg_word[`RXAP_FLD_RUN_HI:`RXAP_FLD_RUN_LO];
    wire [9:0]  wus       = win_us({win_code, bw_code});
    wire [15:0] win_cyc   = {6'h00, wus} * 16'h0028;
    wire [31:0] sleep_len = SLEEP_BASE_CYC << sleep_sel;
    wire [4:0]  need_bits = (run_sel == 2'h0) ? 5'h00 : (5'h02 << run_sel);
    wire        valid_bit;
    wire        bad_bit;

    rxap_bitcheck #(
        .CW (16)
    ) u_check (
        .clk        (mclk),
        .srst       (srst),
        .enable     (astate_reg == A_POLL),
        .level      (slicer_s),
        .window_cyc (win_cyc),
        .valid_bit  (valid_bit),
        .bad_bit    (bad_bit)
    );

    always @(posedge mclk) begin
        if (srst) begin
            astate_reg    <= A_AWAKE;
            sleep_cnt_reg <= 32'h00000000;
            valid_cnt_reg <= 5'h00;
            bad_cnt_reg   <= 3'h0;
        end else if (apply) begin
            // new word: poll bit decides mode, restarting any cycle
            astate_reg    <= cfg_merged[`RXAP_BIT_POLL_EN] ? A_SLEEP : A_AWAKE;
            sleep_cnt_reg <= 32'h00000000;
            valid_cnt_reg <= 5'h00;
            bad_cnt_reg   <= 3'h0;
        end else begin
            case (astate_reg)
                A_SLEEP: begin
                    if (sleep_cnt_reg + 32'h00000001 >= sleep_len) begin
                        astate_reg    <= A_POLL;
                        sleep_cnt_reg <= 32'h00000000;
                    end else begin
                        sleep_cnt_reg <= sleep_cnt_reg + 32'h00000001;
                    end
                end
                A_POLL: begin
                    if (valid_cnt_reg >= need_bits) begin
                        astate_reg <= A_AWAKE;
                    end else if (valid_bit) begin
                        valid_cnt_reg <= valid_cnt_reg + 5'h01;
                        bad_cnt_reg   <= 3'h0;
                    end else if (bad_bit) begin
                        valid_cnt_reg <= 5'h00;
                        if (bad_cnt_reg == `RXAP_BAD_LIMIT - 1) begin
                            astate_reg  <= A_SLEEP;
                            bad_cnt_reg <= 3'h0;
                        end else begin
                            bad_cnt_reg <= bad_cnt_reg + 3'h1;
                        end
                    end
                end
                A_AWAKE: astate_reg <= A_AWAKE;
                default: astate_reg <= A_AWAKE;
            endcase
        end
    end

    // outputs and decoded fields
    always @(posedge mclk) begin
        if (srst) begin
            data_pin_out    <= 1'b0;
            squelch_disable <= 1'b1;
            slice_level_sel <= 2'h3;
            demod_bw_sel    <= 2'h3;
            band_select     <= 2'h0;
            band_low_reg    <= 2'h0;
            sleep_active    <= 1'b0;
            poll_active     <= 1'b0;
            prog_active     <= 1'b0;
        end else begin
            data_pin_out    <= (astate_reg == A_AWAKE) ? slicer_s : 1'b0;
            squelch_disable <= sq_s ^ cfg_word[`RXAP_BIT_SQUELCH];
            slice_level_sel <= cfg_word[`RXAP_FLD_SLICE_HI:`RXAP_FLD_SLICE_LO];
            demod_bw_sel    <= bw_code;
            band_low_reg    <= {band_low_reg[0], band_select_pin_low};
            band_select     <= {pins_s[4], band_low_reg[1]};
            sleep_active    <= (astate_reg == A_SLEEP);
            poll_active     <= (astate_reg == A_POLL);
            prog_active     <= (pstate_reg != P_IDLE);
        end
    end
endmodule
`default_nettype wire

// file: testbench/rxap_assertions.sv
// checker: port assertions on the auto-poll sequencer and serial port
// assumes binding into rxap_top, one mclk domain
`timescale 1ns/1ps
`default_nettype none
module rxap_checker #(
    parameter SLEEP_BASE_CYC = 200
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        sclk_pin,
    input wire logic        squelch_pin,
    input wire logic        data_pin_out,
    input wire logic        data_pin_oe,
    input wire logic [19:0] cfg_word,
    input wire logic        squelch_disable,
    input wire logic [1:0]  slice_level_sel,
    input wire logic [1:0]  demod_bw_sel,
    input wire logic        sleep_active,
    input wire logic        poll_active,
    input wire logic        prog_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic [31:0] sleep_cnt;
    logic [31:0] sleep_len;
    assign sleep_len = SLEEP_BASE_CYC << cfg_word[14:12];
    // consecutive sleep cycles so far
    always @(posedge mclk) begin
        if (srst || !sleep_active)
            sleep_cnt <= 32'h0;
        else
            sleep_cnt <= sleep_cnt + 32'h1;
    end
    oe_fall_a: assert property ($rose(sclk_pin) |-> ##[1:4] !data_pin_oe)
        else $error("data pin still driven after serial clock rise");
    pin_low_a: assert property ((sleep_active || poll_active) && ($past(sleep_active) || $past(poll_active))
        |-> !data_pin_out) else $error("data pin not low while sleeping or polling");
    squelch_a: assert property (!$past(srst, 3) && squelch_pin == $past(squelch_pin, 3)
        && cfg_word[17] == $past(cfg_word[17])
        |-> squelch_disable == (squelch_pin ^ cfg_word[17])) else $error("squelch state wrong");
    slice_bw_a: assert property (cfg_word == $past(cfg_word, 2)
        |-> slice_level_sel == cfg_word[6:5] && demod_bw_sel == cfg_word[4:3]) else $error("field copy wrong");
    cfg_hold_a: assert property (!prog_active && !$past(prog_active) && !$past(prog_active, 3)
        |-> $stable(cfg_word)) else $error("word changed outside programming");
    oe_back_a: assert property ($changed(cfg_word) && !sclk_pin |-> ##[1:3] data_pin_oe)
        else $error("data pin not driven after stop");
    sleep_len_a: assert property ($fell(sleep_active) && !prog_active && !$past(prog_active)
        |-> poll_active && sleep_cnt + 32'h1 >= sleep_len && sleep_cnt <= sleep_len + 32'h1)
        else $error("sleep length wrong");
    awake_keep_a: assert property ($fell(poll_active) ##2 (!sleep_active && !prog_active)
        |-> (!sleep_active && !poll_active) [*8]) else $error("left continuous receive");
endmodule
bind rxap_top rxap_checker #(.SLEEP_BASE_CYC(SLEEP_BASE_CYC)) u_rxap_checker (
    .mclk(mclk), .srst(srst), .sclk_pin(sclk_pin), .squelch_pin(squelch_pin),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .cfg_word(cfg_word),
    .squelch_disable(squelch_disable), .slice_level_sel(slice_level_sel), .demod_bw_sel(demod_bw_sel),
    .sleep_active(sleep_active), .poll_active(poll_active), .prog_active(prog_active)
);
`default_nettype wire

// file: testbench/rxap_host.sv
// host model: frames config writes on serial clock and data pin
// assumes calls to frame() from the bench; moves on falling mclk
`timescale 1ns/1ps
`default_nettype none
module rxap_host (
    input  wire logic mclk,
    input  wire logic data_pin_oe,
    input  wire logic data_pin_out,
    output var logic  sclk_pin,
    output var logic  data_pin_in
);
    logic host_oe = 1'b0;
    logic host_d = 1'b0;
    initial sclk_pin = 1'b0;
    // undriven pin shows the inverse of the last host value
    always @* data_pin_in = data_pin_oe ? data_pin_out : (host_oe ? host_d : ~host_d);
    task automatic phase(input logic s, input logic d, input logic o);
        @(negedge mclk);
        sclk_pin = s;
        host_d = d;
        host_oe = o;
        repeat (7) @(negedge mclk);
    endtask
    task automatic frame(input int n, input logic [19:0] v, input logic stop);
        int i;
        phase(1'b1, 1'b0, 1'b0);
        phase(1'b1, 1'b0, 1'b1);
        phase(1'b0, 1'b0, 1'b1);
        phase(1'b1, 1'b0, 1'b1);
        phase(1'b1, 1'b1, 1'b1);
        phase(1'b1, 1'b0, 1'b1);
        for (i = n - 1; i >= 0; i--) begin
            phase(1'b0, v[i], 1'b1);
            phase(1'b1, v[i], 1'b1);
        end
        if (stop) begin
            phase(1'b1, 1'b0, 1'b1);
            phase(1'b1, 1'b1, 1'b1);
            phase(1'b1, 1'b0, 1'b1);
        end
        phase(1'b0, 1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

// file: testbench/rxap_top_bench.sv
// bench: serial config writes and auto-poll wake-up of rxap_top
// assumes rxap_host drives the serial clock and data pin
`timescale 1ns/1ps
`default_nettype none
module rxap_top_bench;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        slicer_raw = 1'b0;
    logic        squelch_pin = 1'b1;
    logic        sclk_pin, data_pin_in, data_pin_out, data_pin_oe;
    logic [19:0] cfg_word;
    logic        squelch_disable, sleep_active, poll_active, prog_active;
    logic [1:0]  slice_level_sel, demod_bw_sel, band_select;
    logic [19:0] e;
    int          fail_count = 0;
    int          checked = 0;
    int          k;
    int          r;
    always #12.5 mclk = ~mclk;
    rxap_top #(.SLEEP_BASE_CYC(200), .SCLK_TIMEOUT_CYC(1000)) u_rxap_top (
        .mclk(mclk), .srst(srst), .sclk_pin(sclk_pin), .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
        .data_pin_oe(data_pin_oe), .slicer_raw(slicer_raw), .squelch_pin(squelch_pin),
        .band_select_pin_low(1'b1), .band_select_pin_high(1'b1), .cfg_word(cfg_word),
        .squelch_disable(squelch_disable), .slice_level_sel(slice_level_sel), .demod_bw_sel(demod_bw_sel),
        .band_select(band_select), .sleep_active(sleep_active), .poll_active(poll_active), .prog_active(prog_active)
    );
    rxap_host u_rxap_host (.mclk(mclk), .data_pin_oe(data_pin_oe), .data_pin_out(data_pin_out),
        .sclk_pin(sclk_pin), .data_pin_in(data_pin_in));
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_lvl(input logic want);
        int t;
        t = 0;
        while (sleep_active !== want && t < 3000) begin
            @(negedge mclk);
            t++;
        end
        chk(sleep_active, want);
    endtask
    // auto-poll word: sleep 000, window 111, bandwidth 11, slice 11
    function automatic logic [19:0] aword(input int c);
        return {4'h4, 1'b1, 3'h0, 3'h7, c[1:0], 4'hF, 3'h0};
    endfunction
    initial begin
        repeat (12) @(negedge mclk);
        srst = 1'b0;
        // pin levels need the synchroniser and one output register to settle
        repeat (4) @(negedge mclk);
        e = 20'h42E78;
        chk(cfg_word, e);
        chk({squelch_disable, slice_level_sel, demod_bw_sel, data_pin_oe, band_select}, 20'hFF);
        slicer_raw = 1'b1;
        repeat (8) @(negedge mclk);
        chk(data_pin_out, 1'b1);
        e = 20'h43CA8;
        u_rxap_host.frame(20, e, 1'b1);
        chk(cfg_word, e);
        chk({slice_level_sel, demod_bw_sel, data_pin_oe}, 20'h0B);
        for (k = 0; k < 4; k++) begin
            e[6:3] = {k[1:0], k[1:0]};
            u_rxap_host.frame(7, e, 1'b1);
            chk(cfg_word, e);
            chk({slice_level_sel, demod_bw_sel}, {16'h0, k[1:0], k[1:0]});
        end
        u_rxap_host.frame(3, 20'h7, 1'b0);
        repeat (1100) @(negedge mclk);
        chk({cfg_word[18:0], data_pin_oe}, {e[18:0], 1'b1});
        squelch_pin = 1'b0;
        repeat (6) @(negedge mclk);
        chk(squelch_disable, 1'b0);
        e[17] = 1'b1;
        u_rxap_host.frame(18, e, 1'b1);
        chk(squelch_disable, 1'b1);
        squelch_pin = 1'b1;
        repeat (6) @(negedge mclk);
        chk(squelch_disable, 1'b0);
        slicer_raw = 1'b0;
        u_rxap_host.frame(20, aword(1), 1'b1);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        for (k = 0; k < 4; k++) begin
            chk(sleep_active, 1'b0);
            repeat (100) @(negedge mclk);
            slicer_raw = ~slicer_raw;
        end
        repeat (8) @(negedge mclk);
        chk(sleep_active, 1'b1);
        for (r = 0; r < 4; r++) begin
            slicer_raw = 1'b0;
            u_rxap_host.frame(20, aword(r), 1'b1);
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            repeat (4) @(negedge mclk);
            for (k = 0; k < ((r == 0) ? 0 : (2 << r)); k++) begin
                chk(poll_active, 1'b1);
                repeat (1600) @(negedge mclk);
                slicer_raw = ~slicer_raw;
            end
            repeat (8) @(negedge mclk);
            chk({sleep_active, poll_active}, 20'h0);
            slicer_raw = ~slicer_raw;
            repeat (8) @(negedge mclk);
            chk(data_pin_out, slicer_raw);
        end
        repeat (600) @(negedge mclk);
        chk({sleep_active, data_pin_oe}, 20'h1);
        end_sim;
    end
    initial begin
        #2400000;
        fail_count++;
        end_sim;
    end
endmodule
`default_nettype wire
